// ### mar_ctrl.sv
// What this block does
// - Write-protect pin low disables write protection
// - Disable pin high turns both resistors off
// - Completed conversion sets its channel done bit
// - High and low alarm flag per channel
// - Per-channel interrupt enable for alarm conditions
// - Output A optionally asserted on any limit violation
// - Two buffers copy input level to outputs
// - Temperature table gives each resistor its position
// - Results are 16-bit words, 12 bits left-justified
// - Supply and external inputs are unsigned
// - Channels refreshed in fixed round-robin order
// - Compare all results after each update
// - Temperature word is two's complement degrees
// - Index disabled selects manual resistor bytes
// - Main writes refused when protect bit and pin
// - Alarm flags stay set until host clears
`timescale 1ns/100ps
module mar_ctrl
#(
    parameter int NUM_CH = mar_pkg::NUM_CH
)
(
    input  wire logic                              clock,
    input  wire logic                              rst_n,
    input  wire logic                              conv_clock,
    input  wire logic                              conv_rst_n,
    input  wire logic                              conv_valid,
    input  wire logic [mar_pkg::SAMPLE_W-1:0]      conv_data,
    output      logic                              conv_ready,
    output      mar_pkg::mar_chan_e                conv_select,
    input  wire logic                              buffer_in_a,
    input  wire logic                              buffer_in_b,
    input  wire logic                              write_protect_pin,
    input  wire logic                              resistor_disable_pin,
    input  wire logic                              main_protect_bit,
    input  wire logic                              temp_index_enable,
    input  wire logic                              out_a_alarm_enable,
    input  wire logic [NUM_CH-1:0]                 irq_enable,
    input  wire logic [NUM_CH-1:0][15:0]           high_limit,
    input  wire logic [NUM_CH-1:0][15:0]           low_limit,
    input  wire logic [NUM_CH-1:0]                 done_clear,
    input  wire logic [NUM_CH-1:0]                 alarm_high_clear,
    input  wire logic [NUM_CH-1:0]                 alarm_low_clear,
    input  wire logic [mar_pkg::POS_W-1:0]         manual_pos_0,
    input  wire logic [mar_pkg::POS_W-1:0]         manual_pos_1,
    input  wire logic                              table_write,
    input  wire logic [7:0]                        table_addr,
    input  wire logic                              table_resistor,
    input  wire logic [mar_pkg::POS_W-1:0]         table_data,
    output      logic                              main_write_accept,
    output      logic [NUM_CH-1:0][15:0]           result_word,
    output      logic [NUM_CH-1:0]                 conv_done,
    output      logic [NUM_CH-1:0]                 alarm_high,
    output      logic [NUM_CH-1:0]                 alarm_low,
    output      logic                              alarm_irq,
    output      logic                              open_drain_out_a,
    output      logic                              open_drain_out_a_oe,
    output      logic                              open_drain_out_b,
    output      logic                              open_drain_out_b_oe,
    output      logic                              resistor_on,
    output      logic [mar_pkg::POS_W-1:0]         resistor_pos_0,
    output      logic [mar_pkg::POS_W-1:0]         resistor_pos_1
);

    localparam int DEPTH = mar_pkg::TABLE_DEPTH;
    localparam int IW    = mar_pkg::IDX_W;
    localparam int PW    = mar_pkg::POS_W;
    localparam int TEMP  = int'(mar_pkg::CH_TEMP);

    function automatic mar_pkg::mar_chan_e next_chan(
        input mar_pkg::mar_chan_e c
    );
        case (c)
            mar_pkg::CH_VCC:   next_chan = mar_pkg::CH_MON_A;
            mar_pkg::CH_MON_A: next_chan = mar_pkg::CH_MON_B;
            mar_pkg::CH_MON_B: next_chan = mar_pkg::CH_TEMP;
            default:           next_chan = mar_pkg::CH_VCC;
        endcase
    endfunction

    function automatic logic above(
        input logic        signed_cmp,
        input logic [15:0] value,
        input logic [15:0] limit
    );
        above = signed_cmp ? $signed(value) > $signed(limit) : value > limit;
    endfunction

    // Converter side: one result in flight, held until acknowledged
    mar_pkg::mar_link_e  link_state;
    mar_pkg::mar_link_e  next_link_state;
    mar_pkg::mar_chan_e  next_conv_select;
    mar_pkg::mar_result_s hold;
    mar_pkg::mar_result_s next_hold;
    logic                req_tog;
    logic                next_req_tog;
    logic                ack_s1;
    logic                ack_s2;
    logic                ack_tog;

    always_comb
    begin
        next_link_state  = link_state;
        next_conv_select = conv_select;
        next_hold        = hold;
        next_req_tog     = req_tog;
        case (link_state)
            mar_pkg::LINK_IDLE:
            begin
                if (conv_valid)
                begin
                    next_hold.channel = conv_select;
                    next_hold.sample  = conv_data;
                    next_req_tog      = ~req_tog;
                    next_conv_select  = next_chan(conv_select);
                    next_link_state   = mar_pkg::LINK_WAIT;
                end
            end
            mar_pkg::LINK_WAIT:
            begin
                if (ack_s2 == req_tog)
                    next_link_state = mar_pkg::LINK_IDLE;
            end
            default:
                next_link_state = mar_pkg::LINK_IDLE;
        endcase
    end

    always_ff @(posedge conv_clock)
    begin
        if (!conv_rst_n)
        begin
            link_state  <= mar_pkg::LINK_IDLE;
            conv_select <= mar_pkg::CH_VCC;
            hold        <= '0;
            req_tog     <= 1'b0;
            ack_s1      <= 1'b0;
            ack_s2      <= 1'b0;
        end
        else
        begin
            link_state  <= next_link_state;
            conv_select <= next_conv_select;
            hold        <= next_hold;
            req_tog     <= next_req_tog;
            ack_s1      <= ack_tog;
            ack_s2      <= ack_s1;
        end
    end

    assign conv_ready = (link_state == mar_pkg::LINK_IDLE);

    // Main side: pin synchronisers and request edge
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;
    logic       new_result;
    logic       wp_high;
    logic       disable_high;
    logic       buf_a;
    logic       buf_b;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pin_s1 <= 4'hF;
            pin_s2 <= 4'hF;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end
        else
        begin
            pin_s1 <= {resistor_disable_pin, write_protect_pin,
                       buffer_in_b, buffer_in_a};
            pin_s2 <= pin_s1;
            req_s1 <= req_tog;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    assign buf_a        = pin_s2[0];
    assign buf_b        = pin_s2[1];
    assign wp_high      = pin_s2[2];
    assign disable_high = pin_s2[3];
    assign new_result   = req_s2 ^ req_s3;

    assign main_write_accept = ~(main_protect_bit & wp_high);

    // Results, done bits, compare stage and alarm flags
    logic [NUM_CH-1:0][15:0] next_result_word;
    logic [NUM_CH-1:0]       next_conv_done;
    logic [NUM_CH-1:0]       next_alarm_high;
    logic [NUM_CH-1:0]       next_alarm_low;
    logic [NUM_CH-1:0]       out_of_range;
    logic [NUM_CH-1:0]       next_out_of_range;
    logic                    cmp_pending;
    logic                    next_cmp_pending;
    logic                    next_ack_tog;
    logic                    hi_hit;
    logic                    lo_hit;
    logic                    is_signed;
    logic                    next_oe_a;
    logic                    next_oe_b;
    logic                    next_resistor_on;

    always_comb
    begin
        hi_hit            = 1'b0;
        lo_hit            = 1'b0;
        is_signed         = 1'b0;
        next_result_word  = result_word;
        next_out_of_range = out_of_range;
        next_cmp_pending  = new_result;
        next_ack_tog      = new_result ? req_s2 : ack_tog;
        for (int i = 0; i < NUM_CH; i++)
        begin
            is_signed = (i == TEMP);
            hi_hit = above(is_signed, result_word[i], high_limit[i]);
            lo_hit = above(is_signed, low_limit[i], result_word[i]);
            if (cmp_pending)
                next_out_of_range[i] = hi_hit | lo_hit;
            // Set wins over a clear in the same cycle
            next_alarm_high[i] = (alarm_high[i] & ~alarm_high_clear[i])
                | (cmp_pending & hi_hit);
            next_alarm_low[i]  = (alarm_low[i] & ~alarm_low_clear[i])
                | (cmp_pending & lo_hit);
            next_conv_done[i]  = conv_done[i] & ~done_clear[i];
            if (new_result && (int'(hold.channel) == i))
            begin
                next_result_word[i] =
                    {hold.sample, {mar_pkg::JUSTIFY_W{1'b0}}};
                next_conv_done[i] = 1'b1;
            end
        end
        next_oe_a = ~buf_a | (out_a_alarm_enable & (|out_of_range));
        next_oe_b = ~buf_b;
        next_resistor_on = ~disable_high;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            result_word  <= {NUM_CH{mar_pkg::RESULT_RESET}};
            conv_done    <= '0;
            alarm_high   <= '0;
            alarm_low    <= '0;
            out_of_range <= '0;
            cmp_pending  <= 1'b0;
            ack_tog      <= 1'b0;
            open_drain_out_a_oe <= 1'b0;
            open_drain_out_b_oe <= 1'b0;
            resistor_on         <= 1'b0;
        end
        else
        begin
            result_word  <= next_result_word;
            conv_done    <= next_conv_done;
            alarm_high   <= next_alarm_high;
            alarm_low    <= next_alarm_low;
            out_of_range <= next_out_of_range;
            cmp_pending  <= next_cmp_pending;
            ack_tog      <= next_ack_tog;
            open_drain_out_a_oe <= next_oe_a;
            open_drain_out_b_oe <= next_oe_b;
            resistor_on         <= next_resistor_on;
        end
    end

    assign alarm_irq = |((alarm_high | alarm_low) & irq_enable);

    // Open-drain: low is driven, high is released to the pullup
    assign open_drain_out_a = 1'b0;
    assign open_drain_out_b = 1'b0;

    // Temperature table, one byte per step and resistor
    logic [1:0][DEPTH-1:0][PW-1:0] pos_table;
    logic [1:0][DEPTH-1:0][PW-1:0] next_pos_table;
    logic [7:0]                    tbl_off;
    logic signed [8:0]             temp_off;
    logic [IW-1:0]                 temp_idx;
    logic [PW-1:0]                 next_pos_0;
    logic [PW-1:0]                 next_pos_1;

    always_comb
    begin
        next_pos_table = pos_table;
        tbl_off = table_addr - mar_pkg::TABLE_BASE_ADDR;
        // Table writes go through the main address, so protection applies
        if (table_write && main_write_accept && table_addr >=
            mar_pkg::TABLE_BASE_ADDR && tbl_off < 8'(DEPTH))
            next_pos_table[table_resistor][tbl_off[IW-1:0]] = table_data;
        temp_off = $signed({result_word[TEMP][15], result_word[TEMP][15:8]})
            - 9'(mar_pkg::TABLE_MIN_C);
        if (temp_off < 0)
            temp_idx = '0;
        else if (temp_off[8:1] > 8'(DEPTH - 1))
            temp_idx = IW'(DEPTH - 1);
        else
            temp_idx = temp_off[IW:1];
        if (temp_index_enable)
        begin
            next_pos_0 = pos_table[0][temp_idx];
            next_pos_1 = pos_table[1][temp_idx];
        end
        else
        begin
            next_pos_0 = manual_pos_0;
            next_pos_1 = manual_pos_1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pos_table      <= {2 * DEPTH{mar_pkg::POS_RESET}};
            resistor_pos_0 <= mar_pkg::POS_RESET;
            resistor_pos_1 <= mar_pkg::POS_RESET;
        end
        else
        begin
            pos_table      <= next_pos_table;
            resistor_pos_0 <= next_pos_0;
            resistor_pos_1 <= next_pos_1;
        end
    end

endmodule

// ### mar_pkg.sv
package mar_pkg;

    // Channel codes follow a Gray sequence in round-robin order
    typedef enum logic [1:0]
    {
        CH_VCC   = 2'b00,
        CH_MON_A = 2'b01,
        CH_MON_B = 2'b11,
        CH_TEMP  = 2'b10
    } mar_chan_e;

    typedef enum logic
    {
        LINK_IDLE = 1'b0,
        LINK_WAIT = 1'b1
    } mar_link_e;

    localparam int NUM_CH    = 4;
    localparam int SAMPLE_W  = 12;
    localparam int RESULT_W  = 16;
    localparam int JUSTIFY_W = RESULT_W - SAMPLE_W;
    localparam int POS_W     = 8;

    typedef struct packed
    {
        mar_chan_e            channel;
        logic [SAMPLE_W-1:0]  sample;
    } mar_result_s;

    // One supply count is 100 uV, one input count 38.147 uV
    localparam real VCC_LSB_UV = 100.0;
    localparam real MON_LSB_UV = 38.147;

    localparam int TABLE_MIN_C  = -40;
    localparam int TABLE_MAX_C  = 102;
    localparam int TABLE_STEP_C = 2;
    localparam int TABLE_DEPTH  =
        (TABLE_MAX_C - TABLE_MIN_C) / TABLE_STEP_C + 1;
    localparam int IDX_W        = 7;

    localparam logic [7:0] TABLE_BASE_ADDR = 8'h80;
    localparam logic [7:0] MANUAL_ADDR_0   = 8'h82;
    localparam logic [7:0] MANUAL_ADDR_1   = 8'h83;

    localparam logic [POS_W-1:0]    POS_RESET    = 8'h00;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

endpackage

// ### mar_ctrl_chk.sv
`timescale 1ns/100ps
module mar_ctrl_chk
#(
    parameter int NUM_CH = mar_pkg::NUM_CH
)
(
    input logic                    clock,
    input logic                    rst_n,
    input logic                    conv_clock,
    input logic                    conv_rst_n,
    input mar_pkg::mar_chan_e      conv_select,
    input logic                    buffer_in_a,
    input logic                    resistor_disable_pin,
    input logic                    main_protect_bit,
    input logic [NUM_CH-1:0]       irq_enable,
    input logic [NUM_CH-1:0][15:0] high_limit,
    input logic [NUM_CH-1:0]       alarm_high_clear,
    input logic                    main_write_accept,
    input logic [NUM_CH-1:0][15:0] result_word,
    input logic [NUM_CH-1:0]       alarm_high,
    input logic [NUM_CH-1:0]       alarm_low,
    input logic                    alarm_irq,
    input logic                    open_drain_out_a_oe,
    input logic                    resistor_on
);
    a_accept_open:
        assert property (@(posedge clock) disable iff (!rst_n)
            !main_protect_bit |-> main_write_accept)
        else $error("Unprotected write refused");
    // Four samples cover the two sync stages plus the output register
    a_buf_low_drive:
        assert property (@(posedge clock) disable iff (!rst_n)
            (!buffer_in_a)[*4] |-> open_drain_out_a_oe)
        else $error("Out A not pulled low for low input");
    a_rdis_off:
        assert property (@(posedge clock) disable iff (!rst_n)
            resistor_disable_pin[*4] |-> !resistor_on)
        else $error("Resistors on while disabled");
    a_rdis_on:
        assert property (@(posedge clock) disable iff (!rst_n)
            (!resistor_disable_pin)[*4] |-> resistor_on)
        else $error("Resistors off while enabled");
    a_irq_flags:
        assert property (@(posedge clock) disable iff (!rst_n)
            alarm_irq == |((alarm_high | alarm_low) & irq_enable))
        else $error("Interrupt does not match enabled flags");
    a_high_sticky:
        assert property (@(posedge clock) disable iff (!rst_n)
            ($past(alarm_high) & ~$past(alarm_high_clear) & ~alarm_high) == '0)
        else $error("High flag dropped without clear");
    a_vcc_high:
        assert property (@(posedge clock) disable iff (!rst_n)
            $changed(result_word[0]) && result_word[0] > high_limit[0]
                |-> ##[1:2] alarm_high[0])
        else $error("Supply over limit not flagged");
    a_sel_order:
        assert property (@(posedge conv_clock) disable iff (!conv_rst_n)
            $changed(conv_select) |->
                conv_select == {$past(conv_select[0]), ~$past(conv_select[1])})
        else $error("Channel order broken");
endmodule

// ### mar_conv_model.sv
`timescale 1ns/100ps
module mar_conv_model
(
    input  logic               conv_clock,
    input  logic               conv_rst_n,
    input  logic               run,
    input  logic [3:0][11:0]   samples,
    input  logic               conv_ready,
    input  mar_pkg::mar_chan_e conv_select,
    output logic               conv_valid,
    output logic [11:0]        conv_data
);
    initial
    begin
        conv_valid = 1'b0;
        conv_data = 12'h000;
    end
    always @(posedge conv_clock)
    begin
        if (!conv_rst_n)
            conv_valid <= 1'b0;
        else if (conv_valid && conv_ready)
        begin
            // Released data flips so a stale sample never looks valid
            conv_valid <= 1'b0;
            conv_data <= ~conv_data;
        end
        else if (!conv_valid && run && $urandom_range(1) == 1)
        begin
            conv_valid <= 1'b1;
            conv_data <= samples[conv_select];
        end
    end
endmodule

// ### test_mar_ctrl.sv
`timescale 1ns/100ps
module test_mar_ctrl;
    logic               clock, rst_n, conv_clock, conv_rst_n, run;
    logic               conv_valid, conv_ready, table_write, table_resistor;
    logic               buffer_in_a, buffer_in_b, write_protect_pin;
    logic               resistor_disable_pin, main_protect_bit, alarm_irq;
    logic               temp_index_enable, out_a_alarm_enable, resistor_on;
    logic               main_write_accept, open_drain_out_a, open_drain_out_b;
    logic               open_drain_out_a_oe, open_drain_out_b_oe;
    logic [11:0]        conv_data;
    logic [3:0]         irq_enable, done_clear, alarm_high_clear, exp_h;
    logic [3:0]         alarm_low_clear, conv_done, alarm_high, alarm_low;
    logic [3:0]         exp_l;
    logic [3:0][15:0]   high_limit, low_limit, result_word;
    logic [3:0][11:0]   samples;
    logic [7:0]         manual_pos_0, manual_pos_1, table_addr, table_data;
    logic [7:0]         resistor_pos_0, resistor_pos_1, pos0, pos1;
    mar_pkg::mar_chan_e conv_select;
    int                 err_count, n_tests;

    mar_ctrl mar_ctrl_i (.*);
    mar_conv_model mar_conv_model_i (.*);

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        conv_clock = 1'b0;
        #3;
        forever #32 conv_clock = ~conv_clock;
    end

    function automatic logic [7:0] table_slot(input logic [11:0] s);
        int d;
        d = ($signed(s[11:4]) + 40) / 2;
        if (d < 0)
            d = 0;
        if (d > 71)
            d = 71;
        return 8'h80 + 8'(d);
    endfunction
    function automatic logic [1:0] cmp(input int c, input logic [15:0] v,
                                       input logic [15:0] hi, lo);
        if (c == 2)
            return {$signed(v) > $signed(hi), $signed(v) < $signed(lo)};
        return {v > hi, v < lo};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic end_of_test;
        $display("Compares %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic frame;
        int k;
        {done_clear, alarm_high_clear, alarm_low_clear} = 12'hFFF;
        tick(1);
        {done_clear, alarm_high_clear, alarm_low_clear} = 12'h000;
        tick(1);
        check({alarm_high, alarm_low, conv_done}, 12'h000);
        run = 1'b1;
        for (k = 0; k < 2000 && conv_done !== 4'hF; k++)
            tick(1);
        run = 1'b0;
        if (k == 2000)
        begin
            err_count++;
            $display("Error %0t: frame timed out", $time);
            end_of_test();
        end
        // Lets a sample already in flight land before anything changes
        tick(80);
    endtask

    initial
    begin
        int r, c;
        r = $urandom(32'h7e92_ccce);
        {rst_n, conv_rst_n, run, table_write, table_resistor} = '0;
        {buffer_in_a, buffer_in_b, write_protect_pin} = '1;
        {resistor_disable_pin, main_protect_bit} = '0;
        {temp_index_enable, out_a_alarm_enable, irq_enable} = '0;
        {done_clear, alarm_high_clear, alarm_low_clear} = '0;
        {high_limit, low_limit, samples} = '0;
        {manual_pos_0, manual_pos_1, table_addr, table_data} = '0;
        err_count = 0;
        n_tests = 0;
        // Held 14 cycles so the slow link sees two reset edges
        tick(14);
        {rst_n, conv_rst_n} = 2'b11;
        for (r = 0; r < 20; r++)
        begin
            {buffer_in_a, buffer_in_b, write_protect_pin,
             resistor_disable_pin, main_protect_bit} = 5'($urandom);
            tick(4);
            check(open_drain_out_a_oe, !buffer_in_a);
            check(open_drain_out_b_oe, !buffer_in_b);
            check(resistor_on, !resistor_disable_pin);
            check(main_write_accept,
                  !(main_protect_bit && write_protect_pin));
            check({open_drain_out_a, open_drain_out_b}, 2'b00);
        end
        $display("Pin test done");
        {buffer_in_a, write_protect_pin, main_protect_bit} = 3'b110;
        for (r = 0; r < 8; r++)
        begin
            samples = 48'({$urandom, $urandom});
            if (r < 2)
                samples[2] = r ? 12'h7FF : 12'h800;
            high_limit = {$urandom, $urandom};
            low_limit = {$urandom, $urandom};
            {temp_index_enable, out_a_alarm_enable} = {r[0], r[1]};
            {irq_enable, manual_pos_0, manual_pos_1} = 20'($urandom);
            {pos0, pos1} = 16'($urandom);
            for (c = 0; c < 4; c++)
            begin
                if (r == 2)
                    {high_limit[c], low_limit[c]} = {2{samples[c], 4'h0}};
                {exp_h[c], exp_l[c]} =
                    cmp(c, {samples[c], 4'h0}, high_limit[c], low_limit[c]);
            end
            for (c = 0; c < 2; c++)
            begin
                table_addr = table_slot(samples[2]);
                table_resistor = c[0];
                table_data = c ? pos1 : pos0;
                table_write = 1'b1;
                tick(1);
            end
            // Protected write to the same slot must be dropped
            {table_data, table_resistor, main_protect_bit} = {~pos0, 2'b01};
            tick(1);
            {table_write, main_protect_bit} = 2'b00;
            repeat (2) frame();
            for (c = 0; c < 4; c++)
                check(result_word[c], {samples[c], 4'h0});
            check(conv_done, 4'hF);
            check(alarm_high, exp_h);
            check(alarm_low, exp_l);
            check(alarm_irq, |((exp_h | exp_l) & irq_enable));
            check(open_drain_out_a_oe, r[1] && |(exp_h | exp_l));
            check(resistor_pos_0, r[0] ? pos0 : manual_pos_0);
            check(resistor_pos_1, r[0] ? pos1 : manual_pos_1);
        end
        $display("Frame test done");
        end_of_test();
    end
endmodule

bind mar_ctrl mar_ctrl_chk #(.NUM_CH(NUM_CH)) mar_ctrl_chk_i (.*);
